// ---- inc/usart_pkg.sv ----
package usart_pkg;
   // ------------------------------------------------------------
   // frame format
   // ------------------------------------------------------------
   localparam int          CLK_HZ        = 200_000_000;
   localparam int          BAUD_DEFAULT  = 115_200;
   localparam int          DATA_MAX      = 9;
   localparam logic [3:0]  BITS_DEFAULT  = 4'h8;
   localparam logic [3:0]  BITS_MIN      = 4'h5;
   localparam int          RX_DEPTH      = 2;
   localparam logic        LINE_IDLE     = 1'b1;
   localparam logic        START_LEVEL   = 1'b0;
   localparam logic [1:0]  STOP_ONE      = 2'h1;
   localparam logic [1:0]  STOP_TWO      = 2'h2;

   typedef enum logic [2:0] {
      TX_IDLE   = 3'b000,
      TX_START  = 3'b001,
      TX_DATA   = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP   = 3'b100
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE   = 2'b00,
      RX_DATA   = 2'b01,
      RX_PARITY = 2'b10,
      RX_STOP   = 2'b11
   } rx_state_t;
endpackage

// ---- logic/usart_core.sv ----
// Overview of operation
// - buffer-empty flag high when transmit buffer empty, low while it holds data
// - buffer-empty request held while flag, its enable and global enable set
// - data write clears buffer-empty flag; request drops together with the flag
// - done flag sets when frame fully sent and buffer empty
// - done flag clears on interrupt service or written one
// - done request raised when flag set with both enables
// - parity enable inserts parity after last data bit before first stop
// - clearing transmit enable waits until shifter and buffer empty
// - disabled transmitter releases the serial output pin
// - receive enable takes over the serial input pin
// - synchronous mode samples on the external transfer clock
// - reception starts on valid start bit, shifts bits to first stop
// - second stop bit ignored by receiver
// - first stop bit moves frame into receive buffer if a slot is free or a read frees one that cycle
// - unused upper bits of short characters read as zero
// - data read advances receive buffer; status shows next frame
// - parity is xor of data bits, inverted for odd
// - lower parity bit selects odd or even
// - ready flag high while unread data in receive buffer
module usart_core #(
   parameter int BAUD = usart_pkg::BAUD_DEFAULT
) (
   input  wire logic       sys_clk,                // system clock
   input  wire logic       reset,                  // sync reset, high
   input  wire logic       transmitter_enable_bit, // transmit enable
   input  wire logic       receiver_enable_bit,    // receive enable
   input  wire logic       parity_enable_bit,      // parity on
   input  wire logic       parity_odd_select,      // odd parity
   input  wire logic       two_stop_bits,          // two stop bits on transmit
   input  wire logic [3:0] char_bits,              // data bits 5..9
   input  wire logic       sync_mode,              // synchronous operation
   input  wire logic       external_transfer_clock,// xfer clock, sampled
   input  wire logic       global_irq_enable,      // global enable
   input  wire logic       tx_empty_irq_enable,    // empty irq enable
   input  wire logic       tx_done_irq_enable,     // done irq enable
   input  wire logic       tx_done_irq_ack,        // done irq serviced
   input  wire logic       tx_done_clear,          // written one to done
   input  wire logic       data_write,             // write data register
   input  wire logic [7:0] data_wdata,             // low data byte
   input  wire logic       tx_ninth_bit,           // ninth bit to send
   input  wire logic       data_read,              // read data register
   output logic      [7:0] data_window_register,   // low byte of head
   output logic            rx_ninth_bit,           // ninth bit of head
   output logic            frame_error_flag,       // head stop bit bad
   output logic            overrun_flag,           // frame lost
   output logic            parity_error_flag,      // head parity bad
   output logic            rx_ready_flag,          // unread data
   output logic            tx_buffer_empty_flag,   // buffer empty
   output logic            tx_done_flag,           // transmit complete
   output logic            tx_empty_irq,           // empty request
   output logic            tx_done_irq,            // done request
   input  wire logic       serial_in_pin,          // serial input
   output logic            serial_out_pin,         // serial output
   output logic            serial_out_oe_n,        // low: block drives pin
   output logic            serial_in_owned         // high: pin taken by rx
);
   localparam int DIV = usart_pkg::CLK_HZ / BAUD;

   function automatic logic par_of(input logic [8:0] d, input logic [3:0] n,
                                   input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < usart_pkg::DATA_MAX; i++)
         if (4'(i) < n)
            p = p ^ d[i];
      return p;
   endfunction

   // ------------------------------------------------------------
   // bit timing
   // ------------------------------------------------------------
   // sync mode uses the transfer clock edges, else an internal divider
   logic xck_q;
   logic [15:0] tick_cnt_q;
   logic [15:0] rx_cnt_q;
   logic tx_tick, xck_rise, xck_fall, tx_load;
   always_ff @(posedge sys_clk)
      if (reset) xck_q <= 1'b0;
      else       xck_q <= external_transfer_clock;
   assign xck_rise = external_transfer_clock & ~xck_q;
   assign xck_fall = ~external_transfer_clock & xck_q;
   // restart on load, else a start bit from idle can come out cut short
   always_ff @(posedge sys_clk)
      if (reset || tx_load || tick_cnt_q == 16'(DIV - 1)) tick_cnt_q <= 16'h0000;
      else                                     tick_cnt_q <= tick_cnt_q + 16'h0001;
   assign tx_tick = sync_mode ? xck_fall : (tick_cnt_q == 16'(DIV - 1));

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   usart_pkg::tx_state_t tx_state_q;
   logic [8:0] tx_buf_q, tx_sh_q;
   logic       tx_full_q, tx_active_q, tx_on_q, tx_out_q, tx_done_q;
   logic [3:0] tx_idx_q;
   logic       tx_par_q, tx_stop2_q, tx_last;

   assign tx_last = (tx_state_q == usart_pkg::TX_STOP) && tx_tick &&
                    !(two_stop_bits && !tx_stop2_q);
   // shifter reloads when idle or right after the last stop bit
   // sync mode waits for a transfer clock fall so the start bit is whole
   assign tx_load = tx_full_q && tx_on_q &&
                    ((tx_state_q == usart_pkg::TX_IDLE && (!sync_mode || tx_tick)) ||
                     tx_last);

   always_ff @(posedge sys_clk)
      if (reset)
      begin
         tx_full_q <= 1'b0;
         tx_buf_q  <= 9'h000;
      end
      else if (data_write)
      begin
         tx_full_q <= 1'b1;
         tx_buf_q  <= {tx_ninth_bit, data_wdata};
      end
      else if (tx_load)
         tx_full_q <= 1'b0;
   assign tx_buffer_empty_flag = ~tx_full_q;

   // enable drops only once nothing is pending
   always_ff @(posedge sys_clk)
      if (reset) tx_on_q <= 1'b0;
      else if (transmitter_enable_bit) tx_on_q <= 1'b1;
      else if (!tx_full_q && tx_state_q == usart_pkg::TX_IDLE)
         tx_on_q <= 1'b0;

   always_ff @(posedge sys_clk)
      if (reset)
      begin
         tx_state_q <= usart_pkg::TX_IDLE;
         tx_sh_q    <= 9'h000;
         tx_idx_q   <= 4'h0;
         tx_par_q   <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_out_q   <= usart_pkg::LINE_IDLE;
      end
      else if (tx_load)
      begin
         tx_state_q <= usart_pkg::TX_START;
         tx_sh_q    <= tx_buf_q;
         tx_par_q   <= par_of(tx_buf_q, char_bits, parity_odd_select);
         tx_idx_q   <= 4'h0;
         tx_stop2_q <= 1'b0;
         tx_out_q   <= usart_pkg::START_LEVEL;
      end
      else if (tx_tick)
      begin
         unique case (tx_state_q)
            usart_pkg::TX_IDLE:
               tx_out_q <= usart_pkg::LINE_IDLE;
            usart_pkg::TX_START, usart_pkg::TX_DATA:
               if (tx_state_q == usart_pkg::TX_DATA && tx_idx_q == char_bits)
               begin
                  if (parity_enable_bit)
                  begin
                     tx_state_q <= usart_pkg::TX_PARITY;
                     tx_out_q   <= tx_par_q;
                  end
                  else
                  begin
                     tx_state_q <= usart_pkg::TX_STOP;
                     tx_out_q   <= usart_pkg::LINE_IDLE;
                  end
               end
               else
               begin
                  tx_state_q <= usart_pkg::TX_DATA;
                  tx_out_q   <= tx_sh_q[0];
                  tx_sh_q    <= tx_sh_q >> 1;
                  tx_idx_q   <= tx_idx_q + 4'h1;
               end
            usart_pkg::TX_PARITY:
            begin
               tx_state_q <= usart_pkg::TX_STOP;
               tx_out_q   <= usart_pkg::LINE_IDLE;
            end
            usart_pkg::TX_STOP:
               if (two_stop_bits && !tx_stop2_q)
                  tx_stop2_q <= 1'b1;
               else
                  tx_state_q <= usart_pkg::TX_IDLE;
            default:
               tx_state_q <= usart_pkg::TX_IDLE;
         endcase
      end
   assign serial_out_pin  = tx_on_q ? tx_out_q : usart_pkg::LINE_IDLE;
   assign serial_out_oe_n = ~tx_on_q;

   // done flag: set beats clear when both land together
   always_ff @(posedge sys_clk)
      if (reset) tx_done_q <= 1'b0;
      else if (tx_last && !tx_full_q) tx_done_q <= 1'b1;
      else if (tx_done_irq_ack || tx_done_clear) tx_done_q <= 1'b0;
   assign tx_done_flag = tx_done_q;
   assign tx_empty_irq = tx_buffer_empty_flag & tx_empty_irq_enable &
                         global_irq_enable;
   assign tx_done_irq  = tx_done_q & tx_done_irq_enable & global_irq_enable;

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   usart_pkg::rx_state_t rx_state_q;
   logic [8:0]  rx_sh_q;
   logic [3:0]  rx_idx_q;
   logic        rx_pbit_q, rx_wait_q, rx_ovr_q, rx_sample, rx_push, rx_store;
   logic [11:0] rx_fifo_q [usart_pkg::RX_DEPTH];  // {ovr, pe, fe, data9}
   logic [1:0]  rx_cnt_fill_q;
   logic        rx_in;

   assign serial_in_owned = receiver_enable_bit;
   assign rx_in = receiver_enable_bit ? serial_in_pin : usart_pkg::LINE_IDLE;
   // async mode samples mid-bit, counted from the start edge
   assign rx_sample = sync_mode ? xck_rise : (rx_cnt_q == 16'(DIV - 1));
   // constant reset value, else an unknown count never clears
   always_ff @(posedge sys_clk)
      if (reset)
         rx_cnt_q <= 16'(DIV / 2);
      else if (rx_sample ||
               (rx_state_q == usart_pkg::RX_IDLE && !sync_mode && rx_in))
         rx_cnt_q <= (rx_state_q == usart_pkg::RX_IDLE && !rx_sample) ?
                     16'(DIV / 2) : 16'h0000;
      else
         rx_cnt_q <= rx_cnt_q + 16'h0001;

   assign rx_push = rx_sample && rx_state_q == usart_pkg::RX_STOP;
   always_ff @(posedge sys_clk)
      if (reset || !receiver_enable_bit)
      begin
         rx_state_q <= usart_pkg::RX_IDLE;
         rx_sh_q    <= 9'h000;
         rx_idx_q   <= 4'h0;
         rx_pbit_q  <= 1'b0;
      end
      else if (rx_sample)
      begin
         unique case (rx_state_q)
            usart_pkg::RX_IDLE:
               if (rx_in == usart_pkg::START_LEVEL)
               begin
                  rx_state_q <= usart_pkg::RX_DATA;
                  rx_idx_q   <= 4'h0;
                  rx_sh_q    <= 9'h000;
               end
            usart_pkg::RX_DATA:
            begin
               rx_sh_q[rx_idx_q] <= rx_in;
               rx_idx_q          <= rx_idx_q + 4'h1;
               if (rx_idx_q + 4'h1 == char_bits)
                  rx_state_q <= parity_enable_bit ? usart_pkg::RX_PARITY
                                                  : usart_pkg::RX_STOP;
            end
            usart_pkg::RX_PARITY:
            begin
               rx_pbit_q  <= rx_in;
               rx_state_q <= usart_pkg::RX_STOP;
            end
            usart_pkg::RX_STOP:
               rx_state_q <= usart_pkg::RX_IDLE;
         endcase
      end

   // overrun: buffer full, shifter waiting, new start seen
   always_ff @(posedge sys_clk)
      if (reset || !receiver_enable_bit) rx_wait_q <= 1'b0;
      else if (rx_push && rx_cnt_fill_q == 2'(usart_pkg::RX_DEPTH) && !data_read)
         rx_wait_q <= 1'b1;
      else if (rx_wait_q && rx_cnt_fill_q != 2'(usart_pkg::RX_DEPTH))
         rx_wait_q <= 1'b0;
   always_ff @(posedge sys_clk)
      if (reset || !receiver_enable_bit) rx_ovr_q <= 1'b0;
      else if (rx_wait_q && rx_sample && rx_state_q == usart_pkg::RX_IDLE &&
               rx_in == usart_pkg::START_LEVEL)
         rx_ovr_q <= 1'b1;
      else if (rx_store)
         rx_ovr_q <= 1'b0;                 // a lost frame must not clear it

   logic [11:0] rx_entry;
   assign rx_entry = {rx_ovr_q,
                      parity_enable_bit &&
                      (rx_pbit_q != par_of(rx_sh_q, char_bits, parity_odd_select)),
                      rx_in != usart_pkg::LINE_IDLE, rx_sh_q};

   logic pop;
   assign pop = data_read && rx_cnt_fill_q != 2'h0;
   assign rx_store = rx_push && (rx_cnt_fill_q < 2'(usart_pkg::RX_DEPTH) || pop);
   always_ff @(posedge sys_clk)
      if (reset || !receiver_enable_bit)
      begin
         rx_cnt_fill_q <= 2'h0;
         for (int i = 0; i < usart_pkg::RX_DEPTH; i++)
            rx_fifo_q[i] <= 12'h000;
      end
      else
      begin
         if (pop)
            rx_fifo_q[0] <= rx_fifo_q[1];
         if (rx_store)
            rx_fifo_q[pop ? 1'(rx_cnt_fill_q - 2'h1) : 1'(rx_cnt_fill_q)]
               <= rx_entry;
         rx_cnt_fill_q <= rx_cnt_fill_q - {1'b0, pop} + {1'b0, rx_store};
      end

   // upper bits above the character width read as zero
   logic [7:0] rx_mask;
   assign rx_mask = 8'(9'h0ff >> (4'h8 - ((char_bits > 4'h8) ? 4'h8 : char_bits)));
   assign data_window_register = rx_fifo_q[0][7:0] & rx_mask;
   assign rx_ninth_bit      = rx_fifo_q[0][8] & (char_bits > 4'h8);
   assign frame_error_flag  = rx_fifo_q[0][9];
   assign parity_error_flag = rx_fifo_q[0][10];
   assign overrun_flag      = rx_fifo_q[0][11];
   assign rx_ready_flag     = rx_cnt_fill_q != 2'h0;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_empty_after_write;
      @(posedge sys_clk) disable iff (reset) data_write |=> !tx_buffer_empty_flag;
   endproperty
   a_empty_after_write: assert property (p_empty_after_write) else $error("empty flag set after write");
   property p_empty_irq;
      @(posedge sys_clk) disable iff (reset)
         tx_empty_irq == (tx_buffer_empty_flag && tx_empty_irq_enable && global_irq_enable);
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty irq mismatch");
   property p_done_set;
      @(posedge sys_clk) disable iff (reset) (tx_last && !tx_full_q) |=> tx_done_flag;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set");
   property p_done_clr;
      @(posedge sys_clk) disable iff (reset)
         ((tx_done_clear || tx_done_irq_ack) && !(tx_last && !tx_full_q)) |=> !tx_done_flag;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
   property p_release;
      @(posedge sys_clk) disable iff (reset)
         (!transmitter_enable_bit && !tx_full_q && tx_state_q == usart_pkg::TX_IDLE)
         |=> serial_out_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("pin not released");
   property p_hold_on;
      @(posedge sys_clk) disable iff (reset) (tx_full_q && tx_on_q) |=> !serial_out_oe_n;
   endproperty
   a_hold_on: assert property (p_hold_on) else $error("disabled with data pending");
   property p_ready;
      @(posedge sys_clk) disable iff (reset) rx_push && receiver_enable_bit |=> rx_ready_flag;
   endproperty
   a_ready: assert property (p_ready) else $error("ready not set after frame");
   property p_mask;
      @(posedge sys_clk) disable iff (reset)
         char_bits == usart_pkg::BITS_MIN |-> data_window_register[7:5] == 3'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("upper bits not masked");
   c_tx_frame: cover property (@(posedge sys_clk) disable iff (reset) tx_last);
   c_rx_frame: cover property (@(posedge sys_clk) disable iff (reset) rx_push);
   c_overrun:  cover property (@(posedge sys_clk) disable iff (reset) overrun_flag);
endmodule

// ---- verif/serial_peer.sv ----
module serial_peer #(
   parameter int BIT = 25
) (
   input  wire logic       sys_clk,           // system clock
   input  wire logic       serial_out_pin,    // line from block
   input  wire logic       serial_out_oe_n,   // low: block drives
   input  wire logic [3:0] char_bits,         // data bits
   input  wire logic       parity_enable_bit, // parity on
   output logic            rx_line,           // line into block
   output logic [8:0]      got_data,          // last data seen
   output logic            got_par,           // last parity seen
   output int              got_cnt            // frames seen
);
   timeunit 1ns;
   timeprecision 100ps;
   logic line;
   // released pin sits on its pull-up, so a floating driver reads idle
   assign line = serial_out_oe_n ? 1'b1 : serial_out_pin;
   initial
   begin
      rx_line = 1'b1;
      got_cnt = 0;
   end
   // ------------------------------------------------------------
   // capture frames sent by the block
   // ------------------------------------------------------------
   always
   begin
      @(negedge line);
      repeat (BIT / 2) @(posedge sys_clk);
      if (line === 1'b0)
      begin
         got_data = '0;
         for (int i = 0; i < char_bits; i++)
         begin
            repeat (BIT) @(posedge sys_clk);
            got_data[i] = line;
         end
         if (parity_enable_bit)
         begin
            repeat (BIT) @(posedge sys_clk);
            got_par = line;
         end
         repeat (BIT) @(posedge sys_clk);
         got_cnt++;
      end
   end
   // ------------------------------------------------------------
   // send one frame, lsb first, two stop times of idle after it
   // ------------------------------------------------------------
   task automatic send(input logic [8:0] d, input logic p);
      @(negedge sys_clk);
      rx_line = 1'b0;
      repeat (BIT) @(negedge sys_clk);
      for (int i = 0; i < char_bits; i++)
      begin
         rx_line = d[i];
         repeat (BIT) @(negedge sys_clk);
      end
      if (parity_enable_bit)
      begin
         rx_line = p;
         repeat (BIT) @(negedge sys_clk);
      end
      rx_line = 1'b1;
      repeat (2 * BIT) @(negedge sys_clk);
   endtask
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BAUD = 8_000_000;
   logic sys_clk, reset, transmitter_enable_bit, receiver_enable_bit, parity_enable_bit;
   logic parity_odd_select, two_stop_bits, global_irq_enable, tx_empty_irq_enable;
   logic tx_done_irq_enable, tx_done_irq_ack, tx_done_clear, data_write, tx_ninth_bit;
   logic data_read, sync_mode, external_transfer_clock, rx_ninth_bit, frame_error_flag;
   logic overrun_flag, parity_error_flag, rx_ready_flag, tx_buffer_empty_flag;
   logic tx_done_flag, tx_empty_irq, tx_done_irq, serial_in_pin, serial_out_pin;
   logic serial_out_oe_n, serial_in_owned, got_par;
   logic [3:0] char_bits;
   logic [7:0] data_wdata, data_window_register;
   logic [8:0] got_data;
   int         got_cnt, n_fail, n_tests;

   usart_core #(.BAUD(BAUD)) i_usart_core (.sys_clk, .reset, .transmitter_enable_bit,
      .receiver_enable_bit, .parity_enable_bit, .parity_odd_select, .two_stop_bits,
      .char_bits, .sync_mode, .external_transfer_clock, .global_irq_enable,
      .tx_empty_irq_enable, .tx_done_irq_enable, .tx_done_irq_ack, .tx_done_clear,
      .data_write, .data_wdata, .tx_ninth_bit, .data_read, .data_window_register,
      .rx_ninth_bit, .frame_error_flag, .overrun_flag, .parity_error_flag, .rx_ready_flag,
      .tx_buffer_empty_flag, .tx_done_flag, .tx_empty_irq, .tx_done_irq, .serial_in_pin,
      .serial_out_pin, .serial_out_oe_n, .serial_in_owned);
   serial_peer #(.BIT(usart_pkg::CLK_HZ / BAUD)) i_serial_peer (.sys_clk, .serial_out_pin,
      .serial_out_oe_n, .char_bits, .parity_enable_bit, .rx_line(serial_in_pin),
      .got_data, .got_par, .got_cnt);

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // transfer clock, one bit time per period, free running
   initial
   begin
      external_transfer_clock = 1'b0;
      forever
      begin
         repeat (13) @(negedge sys_clk);
         external_transfer_clock = 1'b1;
         repeat (12) @(negedge sys_clk);
         external_transfer_clock = 1'b0;
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [8:0] msk(input logic [8:0] d, input logic [3:0] n);
      return d & ((9'h1 << n) - 9'h1);
   endfunction
   function automatic logic par(input logic [8:0] d, input logic [3:0] n, input logic o);
      return (^msk(d, n)) ^ o;
   endfunction
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [8:0] d);
      tx_ninth_bit = d[8];
      @(negedge sys_clk);
      data_wdata = d[7:0];
      data_write = 1'b1;
      @(negedge sys_clk);
      data_write = 1'b0;
   endtask
   task automatic pop;
      data_read = 1'b1;
      @(negedge sys_clk);
      data_read = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic wait_peer(input int n);
      for (int k = 0; k < 3000 && got_cnt < n; k++) @(negedge sys_clk);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [8:0] a, b;
      logic [3:0] n;
      logic       bad;
      int         base;
      {reset, transmitter_enable_bit, receiver_enable_bit, parity_enable_bit} = 4'h8;
      {parity_odd_select, two_stop_bits, global_irq_enable, tx_empty_irq_enable} = 4'h0;
      {tx_done_irq_enable, tx_done_irq_ack, tx_done_clear, data_write} = 4'h0;
      {tx_ninth_bit, data_read, sync_mode} = 3'h0;
      char_bits = 4'h8;
      data_wdata = 8'h00;
      n_fail = 0;
      n_tests = 0;
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
      chk(tx_buffer_empty_flag, 9'h1);
      chk(tx_done_flag, 9'h0);
      chk(serial_out_oe_n, 9'h1);
      chk(rx_ready_flag, 9'h0);
      transmitter_enable_bit = 1'b1;
      receiver_enable_bit = 1'b1;
      void'($urandom(66969));
      for (int it = 0; it < 8; it++)
      begin
         // corner widths first: nine bits, then five
         n = (it == 0) ? 4'h9 : (it == 1) ? 4'h5 : 4'h5 + 4'($urandom_range(4));
         char_bits = n;
         {parity_enable_bit, parity_odd_select, two_stop_bits} = 3'($urandom);
         {global_irq_enable, tx_empty_irq_enable, tx_done_irq_enable} = 3'($urandom);
         a = 9'($urandom);
         b = 9'($urandom);
         base = got_cnt;
         wr(a);
         repeat (3) @(negedge sys_clk);
         wr(b);
         repeat (3) @(negedge sys_clk);
         chk(tx_buffer_empty_flag, 9'h0);
         chk(tx_empty_irq, 9'h0);
         wait_peer(base + 1);
         chk(got_data, msk(a, n));
         chk(got_par, parity_enable_bit ? par(a, n, parity_odd_select) : got_par);
         chk(tx_done_flag, 9'h0);
         wait_peer(base + 2);
         chk(got_data, msk(b, n));
         chk(got_par, parity_enable_bit ? par(b, n, parity_odd_select) : got_par);
         for (int k = 0; k < 200 && tx_done_flag !== 1'b1; k++) @(negedge sys_clk);
         chk(tx_done_flag, 9'h1);
         chk(tx_buffer_empty_flag, 9'h1);
         chk(tx_empty_irq, global_irq_enable & tx_empty_irq_enable);
         chk(tx_done_irq, global_irq_enable & tx_done_irq_enable);
         tx_done_clear = it[0];
         tx_done_irq_ack = ~it[0];
         @(negedge sys_clk);
         {tx_done_clear, tx_done_irq_ack} = 2'h0;
         chk(tx_done_flag, 9'h0);
         // receive two frames, the first with a bad parity now and then
         bad = (it % 3 == 2) & parity_enable_bit;
         i_serial_peer.send(a, par(a, n, parity_odd_select) ^ bad);
         i_serial_peer.send(b, par(b, n, parity_odd_select));
         chk(rx_ready_flag, 9'h1);
         chk(parity_error_flag, bad);
         chk(frame_error_flag, 9'h0);
         chk({(n == 4'h9) & rx_ninth_bit, data_window_register}, msk(a, n));
         pop;
         chk(parity_error_flag, 9'h0);
         chk({(n == 4'h9) & rx_ninth_bit, data_window_register}, msk(b, n));
         pop;
         chk(rx_ready_flag, 9'h0);
      end
      // synchronous pass: bits follow the transfer clock
      {sync_mode, parity_enable_bit, parity_odd_select, two_stop_bits} = 4'hc;
      char_bits = 4'h8;
      @(negedge external_transfer_clock);
      base = got_cnt;
      wr(9'h05a);
      wait_peer(base + 1);
      chk(got_data, 9'h05a);
      chk(got_par, par(9'h05a, 4'h8, 1'b0));
      @(negedge external_transfer_clock);
      i_serial_peer.send(9'h0c3, par(9'h0c3, 4'h8, 1'b0));
      chk({rx_ninth_bit, data_window_register}, 9'h0c3);
      chk(parity_error_flag, 9'h0);
      pop;
      sync_mode = 1'b0;
      // overrun: two held, a third waits, the fourth start marks the loss
      for (int k = 0; k < 4; k++)
         i_serial_peer.send(9'(k), par(9'(k), 4'h8, 1'b0));
      chk(overrun_flag, 9'h0);
      chk({rx_ninth_bit, data_window_register}, 9'h000);
      pop;
      chk({rx_ninth_bit, data_window_register}, 9'h001);
      pop;
      i_serial_peer.send(9'h011, par(9'h011, 4'h8, 1'b0));
      chk(overrun_flag, 9'h1);
      chk({rx_ninth_bit, data_window_register}, 9'h011);
      pop;
      // disable while a frame is still on the line
      base = got_cnt;
      wr(9'h0a5);
      transmitter_enable_bit = 1'b0;
      repeat (50) @(negedge sys_clk);
      chk(serial_out_oe_n, 9'h0);
      wait_peer(base + 1);
      repeat (60) @(negedge sys_clk);
      chk(serial_out_oe_n, 9'h1);
      chk(serial_out_pin, 9'h1);
      chk(serial_in_owned, 9'h1);
      receiver_enable_bit = 1'b0;
      @(negedge sys_clk);
      chk(serial_in_owned, 9'h0);
      close_out;
   end
   // a hang costs about six to nine times the expected run
   initial
   begin
      #400_000;
      n_fail++;
      close_out;
   end
endmodule
